/* File: shared/asa_pkg.sv */
package asa_pkg;
	localparam logic [3:0] ADDR_ACT = 4'h1;
	localparam logic [3:0] ADDR_ANG = 4'h2;
	localparam logic [3:0] ADDR_STAT = 4'h0;
	localparam logic [3:0] ADDR_FUSE_LO = 4'h8;
	localparam logic [3:0] ADDR_FUSE_HI = 4'hf;
	localparam logic [15:0] ACT_RESET = 16'h18ee;
	localparam logic [15:0] ANG_RESET = 16'h8000;
	localparam logic [4:0] RSV_RESET = 5'h03;
	localparam logic [4:0] RSV_RUN = 5'h0b;
	localparam int B_ADCT = 9;
	localparam int B_MAG = 7;
	localparam int B_XY = 6;
	localparam int B_OV = 5;
	localparam int B_BIST = 4;
	localparam int B_CRC = 3;
	localparam int B_VR = 2;
	localparam int B_WD = 1;
	localparam int B_RST = 0;
	localparam int B_FRESH = 15;
	localparam int ANG_W = 15;
	localparam logic [15:0] WMASK = 16'h02fe;
	localparam int CMD_W = 16;
	localparam int CLK_MHZ = 250;
	localparam int TEST_NS = 400;
	localparam int TEST_CYC = (TEST_NS * CLK_MHZ + 999) / 1000;
	localparam logic [15:0] CMD_RW_BIT = 16'h8000;
	localparam logic [15:0] CMD_UPD_BIT = 16'h0400;

	typedef struct packed {
		logic valid;
		logic rd;
		logic upd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} asa_req_s;

	typedef struct packed {
		logic crc_err;
		logic vr_err;
		logic wd_err;
		logic mag_err;
		logic xy_err;
		logic ov_err;
	} asa_err_s;
endpackage

/* File: src/asa_serial.sv */
`timescale 1ns/1ps
module asa_serial
	import asa_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic [15:0] rdata_i,
	output logic miso_o,
	output logic miso_oe_o,
	output asa_req_s req_o,
	output logic cs_rise_o
);
	typedef struct packed {
		logic [1:0] sck_s;
		logic [1:0] cs_s;
		logic [1:0] di_s;
		logic sck_p;
		logic cs_p;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [15:0] cmd;
		logic have_cmd;
		logic [15:0] tx;
		logic miso;
		logic oe;
		asa_req_s req;
		logic rise;
		logic ld;
	} st_s;
	st_s q, d;

	always_comb begin
		d = q;
		d.sck_s = {q.sck_s[0], sck_i};
		d.cs_s = {q.cs_s[0], cs_n_i};
		d.di_s = {q.di_s[0], mosi_i};
		d.sck_p = q.sck_s[1];
		d.cs_p = q.cs_s[1];
		d.req.valid = 1'b0;
		d.rise = 1'b0;
		if (q.cs_s[1]) begin
			d.cnt = 5'h00;
			d.have_cmd = 1'b0;
			d.oe = 1'b0;
			if (!q.cs_p) begin
				d.rise = 1'b1;
			end
		end else if (q.sck_s[1] && !q.sck_p) begin
			d.sh = {q.sh[14:0], q.di_s[1]};
			d.cnt = q.cnt + 5'h01;
			if (q.cnt == 5'h0f) begin
				d.cnt = 5'h00;
				if (!q.have_cmd) begin
					d.cmd = {q.sh[14:0], q.di_s[1]};
					d.have_cmd = 1'b1;
					d.req.valid = 1'b1;
					d.req.rd = d.cmd[15];
					d.req.upd = (d.cmd & CMD_UPD_BIT) != 16'h0000;
					d.req.addr = d.cmd[7:4];
					d.req.wdata = 16'h0000;
				end else if (!q.cmd[15]) begin
					d.req.valid = 1'b1;
					d.req.rd = 1'b0;
					d.req.upd = 1'b0;
					d.req.addr = q.cmd[7:4];
					d.req.wdata = {q.sh[14:0], q.di_s[1]};
				end
			end
		end else if (!q.sck_s[1] && q.sck_p && q.have_cmd && q.cmd[15]) begin
			// Shift out on falling edge so the host samples a settled bit
			d.oe = 1'b1;
			d.miso = q.tx[15];
			d.tx = {q.tx[14:0], 1'b0};
		end
		// Register data stands one cycle after the request, so load a cycle later
		d.ld = q.req.valid && q.req.rd;
		if (q.ld) begin
			d.tx = rdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.cs_s <= 2'b11;
			q.cs_p <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign miso_o = q.miso;
	assign miso_oe_o = q.oe;
	assign req_o = q.req;
	assign cs_rise_o = q.rise;
endmodule

/* File: src/asa_selftest.sv */
`timescale 1ns/1ps
module asa_selftest
	import asa_pkg::*;
#(
	parameter int CYCLES = TEST_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	output logic busy_o
);
	typedef struct packed {
		logic busy;
		logic [15:0] cnt;
	} st_s;
	st_s q, d;

	always_comb begin
		d = q;
		if (start_i && !q.busy) begin
			d.busy = 1'b1;
			d.cnt = 16'(CYCLES - 1);
		end else if (q.busy) begin
			if (q.cnt == 16'h0000) begin
				d.busy = 1'b0;
			end else begin
				d.cnt = q.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy_o = q.busy;
endmodule

/* File: src/asa_regs.sv */
`timescale 1ns/1ps
module asa_regs
	import asa_pkg::*;
#(
	parameter int TEST_CYCLES = TEST_CYC
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic auto_cal_i,
	input wire logic angle_valid_i,
	input wire logic [ANG_W-1:0] angle_i,
	input wire logic rsv_run_i,
	input wire asa_err_s err_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic [5:0] monitor_en_o,
	output logic adc_test_busy_o,
	output logic proc_selftest_busy_o,
	output logic hw_reset_o,
	output logic [6:0] status_o
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	asa_req_s req;
	logic cs_rise;
	logic ser_miso;
	logic ser_oe;
	logic bist_busy;
	logic adc_busy;
	logic bist_start;
	logic adc_start;

	typedef struct packed {
		logic [4:0] rsv;
		logic adct;
		logic mag;
		logic xy;
		logic ov;
		logic crc;
		logic vr;
		logic wd;
		logic rst_pend;
		logic [15:0] act_buf;
		logic fresh;
		logic fresh_buf;
		logic [ANG_W-1:0] ang;
		logic [ANG_W-1:0] ang_buf;
		logic [6:0] stat;
		logic [15:0] rdata;
		logic bist_go;
		logic adc_go;
		logic hw_rst;
		logic miso;
		logic oe;
		logic [5:0] en_o;
		logic adc_o;
		logic bist_o;
	} st_s;
	st_s q, d;

	function automatic logic [15:0] act_word(input st_s s, input logic bist, input logic adc);
		act_word = {s.rsv, 1'b0, adc, 1'b0, s.mag, s.xy, s.ov, bist, s.crc, s.vr, s.wd, 1'b0};
	endfunction

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	asa_serial u_serial (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.sck_i(sck_i),
		.cs_n_i(cs_n_i),
		.mosi_i(mosi_i),
		.rdata_i(q.rdata),
		.miso_o(ser_miso),
		.miso_oe_o(ser_oe),
		.req_o(req),
		.cs_rise_o(cs_rise)
	);

	asa_selftest #(.CYCLES(TEST_CYCLES)) u_bist (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.start_i(bist_start),
		.busy_o(bist_busy)
	);

	asa_selftest #(.CYCLES(TEST_CYCLES)) u_adct (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.start_i(adc_start),
		.busy_o(adc_busy)
	);

	assign bist_start = q.bist_go;
	assign adc_start = q.adc_go;

	always_comb begin
		logic wr_act;
		logic rd_any;
		logic [15:0] w;
		logic [6:0] set;
		wr_act = req.valid && !req.rd && req.addr == ADDR_ACT;
		rd_any = req.valid && req.rd;
		w = req.wdata;
		set = 7'h00;
		d = q;
		d.bist_go = 1'b0;
		d.adc_go = 1'b0;
		d.hw_rst = 1'b0;
		// Reserved field is device owned; host data never reaches it
		d.rsv = rsv_run_i ? RSV_RUN : RSV_RESET;
		if (wr_act) begin
			d.mag = w[B_MAG];
			d.xy = w[B_XY];
			d.ov = w[B_OV];
			d.crc = w[B_CRC];
			d.vr = w[B_VR];
			d.wd = w[B_WD];
			d.bist_go = w[B_BIST];
			// Ignored under auto calibration, the check would read moving data
			d.adc_go = w[B_ADCT] && !auto_cal_i;
			if (w[B_RST]) begin
				d.rst_pend = 1'b1;
			end
		end
		if (req.valid && !req.rd && req.addr >= ADDR_FUSE_LO && req.addr <= ADDR_FUSE_HI) begin
			d.crc = 1'b1;
		end
		if (cs_rise && q.rst_pend) begin
			d.rst_pend = 1'b0;
			d.hw_rst = 1'b1;
		end
		// Error latches: enable gates new errors, old ones wait for readout, except WD, dropped by an ACT write with its enable bit 0
		set[6] = err_i.mag_err && q.mag;
		set[5] = err_i.xy_err && q.xy;
		set[4] = err_i.ov_err && q.ov;
		set[3] = err_i.crc_err && q.crc && !auto_cal_i;
		set[2] = err_i.vr_err && q.vr;
		set[1] = err_i.wd_err && q.wd;
		set[0] = q.hw_rst;
		if (rd_any && req.addr == ADDR_STAT) begin
			d.stat = set;
		end else begin
			d.stat = q.stat | set;
		end
		if (wr_act && !w[B_WD]) begin
			d.stat[1] = 1'b0;
		end
		if (angle_valid_i) begin
			d.ang = angle_i;
		end
		if (req.valid && req.upd) begin
			// Snapshot hands the fresh flag to the buffer, live flag is consumed
			d.act_buf = act_word(q, bist_busy, adc_busy);
			d.ang_buf = q.ang;
			d.fresh_buf = q.fresh;
			d.fresh = 1'b0;
		end
		d.rdata = 16'h0000;
		if (rd_any) begin
			unique case (req.addr)
				ADDR_STAT: d.rdata = {9'h000, q.stat};
				ADDR_ACT: d.rdata = req.upd ? q.act_buf : act_word(q, bist_busy, adc_busy);
				ADDR_ANG: begin
					d.rdata = req.upd ? {q.fresh_buf, q.ang_buf} : {q.fresh, q.ang};
					// Plain read consumes the live flag; an update read already cleared it in the snapshot above
					if (!req.upd) begin
						d.fresh = 1'b0;
					end
				end
				default: d.rdata = 16'h0000;
			endcase
		end
		// New value wins over a clearing read in the same cycle
		if (angle_valid_i) begin
			d.fresh = 1'b1;
		end
		d.miso = ser_miso;
		d.oe = ser_oe;
		d.en_o = {q.mag, q.xy, q.ov, q.crc && !auto_cal_i, q.vr, q.wd};
		d.adc_o = adc_busy;
		d.bist_o = bist_busy;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.rsv <= RSV_RESET;
			q.mag <= ACT_RESET[B_MAG];
			q.xy <= ACT_RESET[B_XY];
			q.ov <= ACT_RESET[B_OV];
			q.crc <= ACT_RESET[B_CRC];
			q.vr <= ACT_RESET[B_VR];
			q.wd <= ACT_RESET[B_WD];
			q.bist_go <= ACT_RESET[B_BIST];
			q.adc_go <= ACT_RESET[B_ADCT];
			q.fresh <= ANG_RESET[B_FRESH];
			q.stat <= 7'h01;
			q.en_o <= 6'h3f;
		end else begin
			q <= d;
		end
	end

	assign miso_o = q.miso;
	assign miso_oe_o = q.oe;
	assign monitor_en_o = q.en_o;
	assign adc_test_busy_o = q.adc_o;
	assign proc_selftest_busy_o = q.bist_o;
	assign hw_reset_o = q.hw_rst;
	assign status_o = q.stat;
endmodule

/* File: tb/asa_host.sv */
`timescale 1ns/1ps
module asa_host (
	input wire logic clk_i,
	input wire logic miso_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic mosi_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Ten clocks per half gives the 80 ns link period
	task automatic frame(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = '0;
		cs_n_o <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			mosi_o <= sh[31 - i];
			repeat (10) @(posedge clk_i);
			sck_o <= 1'b1;
			rd = {rd[14:0], miso_i};
			repeat (10) @(posedge clk_i);
			sck_o <= 1'b0;
		end
		repeat (10) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// Released line must not keep its last bit
		mosi_o <= ~mosi_o;
		repeat (20) @(posedge clk_i);
	endtask
endmodule

/* File: tb/asa_regs_sva.sv */
`timescale 1ns/1ps
module asa_regs_sva
	import asa_pkg::*;
#(
	parameter int TEST_CYCLES = TEST_CYC
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic cs_n_i,
	input wire logic auto_cal_i,
	input wire asa_err_s err_i,
	input wire logic [5:0] monitor_en_o,
	input wire logic adc_test_busy_o,
	input wire logic proc_selftest_busy_o,
	input wire logic hw_reset_o,
	input wire logic [6:0] status_o
);
	localparam int TMAX = TEST_CYCLES + 8;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_quiet;
		cs_n_i [*6];
	endsequence
	sequence s_cal;
		auto_cal_i [*3];
	endsequence
	sequence s_xy_off;
		(!monitor_en_o[4] && !status_o[5]) [*4];
	endsequence
	property p_rst_pulse;
		hw_reset_o |=> !hw_reset_o;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("reset pulse too long");
	property p_rst_flag;
		hw_reset_o |-> ##[0:2] status_o[0];
	endproperty
	a_rst_flag: assert property (p_rst_flag)
		else $error("reset flag not set");
	property p_rst_cs;
		hw_reset_o |-> cs_n_i;
	endproperty
	a_rst_cs: assert property (p_rst_cs)
		else $error("reset before select release");
	property p_crc_cal;
		s_cal |-> !monitor_en_o[2];
	endproperty
	a_crc_cal: assert property (p_crc_cal)
		else $error("crc check on under calibration");
	property p_adc_cal;
		$rose(adc_test_busy_o) |-> !auto_cal_i;
	endproperty
	a_adc_cal: assert property (p_adc_cal)
		else $error("adc test under calibration");
	property p_bist_end;
		$rose(proc_selftest_busy_o) |-> ##[1:TMAX] !proc_selftest_busy_o;
	endproperty
	a_bist_end: assert property (p_bist_end)
		else $error("self test never ends");
	property p_adc_end;
		$rose(adc_test_busy_o) |-> ##[1:TMAX] !adc_test_busy_o;
	endproperty
	a_adc_end: assert property (p_adc_end)
		else $error("adc test never ends");
	property p_wd_clr;
		$fell(monitor_en_o[0]) |-> ##[0:1] !status_o[1];
	endproperty
	a_wd_clr: assert property (p_wd_clr)
		else $error("watchdog flag kept");
	property p_keep;
		s_quiet |-> (~status_o & $past(status_o)) == 7'h00;
	endproperty
	a_keep: assert property (p_keep)
		else $error("status cleared without read");
	property p_mag_set;
		err_i.mag_err && monitor_en_o[5] |-> ##[1:3] status_o[6];
	endproperty
	a_mag_set: assert property (p_mag_set)
		else $error("magnitude error lost");
	property p_xy_off;
		s_xy_off |=> !status_o[5];
	endproperty
	a_xy_off: assert property (p_xy_off)
		else $error("disabled limit error shown");
endmodule
bind asa_regs asa_regs_sva #(.TEST_CYCLES(TEST_CYCLES)) i_sva (.clk_i, .rstn_i, .cs_n_i,
	.auto_cal_i, .err_i, .monitor_en_o, .adc_test_busy_o, .proc_selftest_busy_o, .hw_reset_o,
	.status_o);

/* File: tb/asa_regs_test.sv */
`timescale 1ns/1ps
module asa_regs_test;
	import asa_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic sck_i, cs_n_i, mosi_i, miso_o, miso_oe_o, hw_reset_o, adc_test_busy_o;
	logic proc_selftest_busy_o;
	logic auto_cal_i = 1'b0;
	logic angle_valid_i = 1'b0;
	logic rsv_run_i = 1'b0;
	logic [ANG_W-1:0] angle_i = '0;
	asa_err_s err_i = '0;
	logic [5:0] monitor_en_o;
	logic [6:0] status_o;
	logic [15:0] act_m, ang_m, buf_m, d;
	logic [14:0] codes [3] = '{15'h4000, 15'h0000, 15'h3fff};
	int bad_count = 0, check_count = 0, seed = 84, rst_seen, bist_seen, adc_seen, oe_seen;
	always #2 clk_i = ~clk_i;
	asa_regs #(.TEST_CYCLES(4)) i_dut (.clk_i, .rstn_i, .sck_i, .cs_n_i, .mosi_i, .auto_cal_i,
		.angle_valid_i, .angle_i, .rsv_run_i, .err_i, .miso_o, .miso_oe_o, .monitor_en_o,
		.adc_test_busy_o, .proc_selftest_busy_o, .hw_reset_o, .status_o);
	asa_host i_host (.clk_i, .miso_i(miso_o), .sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i));
	always @(posedge clk_i) begin
		if (hw_reset_o === 1'b1) rst_seen++;
		if (proc_selftest_busy_o === 1'b1) bist_seen = 1;
		if (adc_test_busy_o === 1'b1) adc_seen = 1;
		if (miso_oe_o === 1'b1) oe_seen = 1;
	end
	task automatic wrap_up();
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic u);
		i_host.frame({1'b1, 4'h0, u, 2'h0, a, 4'h0}, 16'h5a5a, d);
		// Any update command moves the live fresh flag into the buffer
		if (u) begin
			buf_m = ang_m;
			ang_m[B_FRESH] = 1'b0;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		i_host.frame({8'h00, a, 4'h0}, v, d);
		// Test starters read back zero once done
		if (a == ADDR_ACT) act_m = v & WMASK & 16'hfdee;
		else if (a >= ADDR_FUSE_LO) act_m[B_CRC] = 1'b1;
	endtask
	function automatic logic [15:0] act_x();
		return {rsv_run_i ? RSV_RUN : RSV_RESET, act_m[10:0]};
	endfunction
	task automatic hit(input asa_err_s e);
		err_i <= e;
		repeat (2) @(posedge clk_i);
		err_i <= '0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic new_angle(input logic [14:0] c);
		angle_i <= c;
		angle_valid_i <= 1'b1;
		@(posedge clk_i);
		angle_valid_i <= 1'b0;
		ang_m = {1'b1, c};
		repeat (4) @(posedge clk_i);
	endtask
	task automatic rd_ang(input logic u);
		logic [15:0] e;
		e = u ? buf_m : ang_m;
		rd(ADDR_ANG, u);
		chk(d, e);
		ang_m[B_FRESH] = 1'b0;
	endtask
	initial begin
		#300us;
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		act_m = 16'h00ee;
		ang_m = ANG_RESET;
		buf_m = 16'h0000;
		chk({10'h0, monitor_en_o}, 16'h003f);
		chk({9'h0, status_o}, 16'h0001);
		rd(ADDR_ACT, 1'b0);
		chk(d, act_x());
		chk({14'h0, oe_seen[0], miso_oe_o}, 16'h0002);
		rd(ADDR_ACT, 1'b1);
		chk(d, 16'h0000);
		rd(ADDR_ACT, 1'b1);
		chk(d, act_x());
		rsv_run_i <= 1'b1;
		rd(ADDR_ACT, 1'b0);
		chk(d, act_x());
		rsv_run_i <= 1'b0;
		rd(ADDR_STAT, 1'b0);
		chk(d, 16'h0001);
		chk({9'h0, status_o}, 16'h0000);
		rst_seen = 0;
		bist_seen = 0;
		adc_seen = 0;
		wr(ADDR_ACT, 16'hffff);
		chk(16'(rst_seen), 16'h0001);
		chk({9'h0, status_o}, 16'h0001);
		chk(16'(bist_seen + adc_seen), 16'h0002);
		rd(ADDR_ACT, 1'b0);
		chk(d, act_x());
		wr(ADDR_ACT, 16'h0000);
		chk({10'h0, monitor_en_o}, 16'h0000);
		rd(ADDR_ACT, 1'b0);
		chk(d, act_x());
		rd(ADDR_STAT, 1'b0);
		hit('1);
		chk({9'h0, status_o}, 16'h0000);
		wr(ADDR_FUSE_LO | 4'($random(seed)), 16'($random(seed)));
		chk({10'h0, monitor_en_o}, 16'h0004);
		auto_cal_i <= 1'b1;
		adc_seen = 0;
		wr(ADDR_ACT, 16'h0208);
		chk({10'h0, monitor_en_o}, 16'h0000);
		chk(16'(adc_seen), 16'h0000);
		rd(ADDR_ACT, 1'b0);
		chk(d, act_x());
		auto_cal_i <= 1'b0;
		wr(ADDR_ACT, 16'h00ee);
		hit('1);
		chk({9'h0, status_o}, 16'h007e);
		wr(ADDR_ACT, 16'h00ec);
		chk({9'h0, status_o}, 16'h007c);
		rd(ADDR_STAT, 1'b0);
		chk(d, 16'h007c);
		chk({9'h0, status_o}, 16'h0000);
		rd_ang(1'b0);
		foreach (codes[i]) begin
			new_angle(codes[i]);
			rd_ang(1'b0);
			rd_ang(1'b1);
		end
		new_angle(15'($random(seed)));
		rd_ang(1'b1);
		rd_ang(1'b1);
		wrap_up();
	end
endmodule
